/* hdl/lpcd_pkg.sv */
// Constants and types shared by both ends of the command link.
// Assumes one system clock shared by controller and device ends.
// How it works
// - Command lines sampled on rising clock only
// - Chip select high starts no command
// - Deselect and no-operation leave state untouched
// - Activate opens addressed row in bank
// - Read starts burst at given column
// - Write starts burst at given column
// - Address bit ten selects auto precharge once
// - Auto precharge closes row after burst
// - Terminate with CKE high, else deep_power_down
// - Controller terminates only plain read bursts
// - Terminate cuts latest read, row stays open
// - Precharge all banks when bit ten high
// - Controller waits precharge time, then activates
// - Controller precharges before opening other row
// - Refresh with CKE high, else self refresh
// - Refresh uses internal counter for cycle time
// - Controller issues every auto refresh separately
// - Self refresh ignores all but CKE
// - Mode load only when idle, then wait
// - Bank bits choose mode, extended, status register
// - Mask low stores byte, high keeps memory
// - Controller keeps clock until bursts complete
// - Controller refreshes around self refresh
// - Deep power-down loses stored contents
package lpcd_pkg;
  localparam int ROW_W      = 14;
  localparam int COL_W      = 10;
  localparam int ADDR_W     = 14;
  localparam int BANK_W     = 2;
  localparam int NBANK      = 4;
  localparam int DATA_W     = 16;
  localparam int BYTES      = DATA_W / 8;
  localparam int AP_BIT     = 10;
  localparam int BURST_LEN  = 4;
  localparam int CLK_MHZ    = 125;
  localparam int T_RFC_NS   = 72;
  localparam int T_RP_NS    = 15;
  localparam int T_MRD_NS   = 10;
  localparam int RFC_CYC    = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int RP_CYC     = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int MRD_CYC    = (T_MRD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [1:0] MR_STD = 2'h0;
  localparam logic [1:0] MR_EXT = 2'h2;
  localparam logic [1:0] MR_STS = 2'h1;

  // Command pins: cs_n, ras_n, cas_n, we_n
  typedef enum logic [3:0] {
    LPCD_NOP   = 4'h7,
    LPCD_ACT   = 4'h3,
    LPCD_RD    = 4'h5,
    LPCD_WR    = 4'h4,
    LPCD_BST   = 4'h6,
    LPCD_PRE   = 4'h2,
    LPCD_REF   = 4'h1,
    LPCD_MRS   = 4'h0,
    LPCD_DESEL = 4'hF
  } lpcd_cmd_e;
endpackage : lpcd_pkg

/* hdl/lpcd_if.sv */
// Command, address and write-data link between controller and device.
// Assumes both ends run on one clock; write data travels with its mask.
interface lpcd_if;
  logic                        cke;
  logic                        cs_n;
  logic                        ras_n;
  logic                        cas_n;
  logic                        we_n;
  logic [lpcd_pkg::BANK_W-1:0] ba;
  logic [lpcd_pkg::ADDR_W-1:0] addr;
  logic                        wd_valid;
  logic [lpcd_pkg::DATA_W-1:0] wd;
  logic [lpcd_pkg::BYTES-1:0]  dm;
  logic                        wd_ready;

  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, wd_valid, wd, dm,
    input  wd_ready
  );
  modport dev (
    input  cke, cs_n, ras_n, cas_n, we_n, ba, addr, wd_valid, wd, dm,
    output wd_ready
  );
endinterface : lpcd_if

/* hdl/lpcd_fifo.sv */
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and asynchronous active-low reset.
module lpcd_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  // Refuse depths the wrapping pointers cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("lpcd_fifo depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } lpcd_fifo_s;

  lpcd_fifo_s st_reg;
  lpcd_fifo_s st_next;
  logic       push;
  logic       pop;

  // Handshakes and pointer update
  always_comb
  begin
    push    = in_valid_i && (st_reg.cnt != (AW+1)'(DEPTH));
    pop     = out_ready_i && (st_reg.cnt != '0);
    st_next = st_reg;
    if (push)
    begin
      st_next.mem[st_reg.wp] = in_data_i;
      st_next.wp = st_reg.wp + 1'b1;
    end
    if (pop)
      st_next.rp = st_reg.rp + 1'b1;
    st_next.cnt = st_reg.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign in_ready_o  = st_reg.cnt != (AW+1)'(DEPTH);
  assign out_valid_o = st_reg.cnt != '0;
  assign out_data_o  = st_reg.mem[st_reg.rp];
endmodule : lpcd_fifo

/* hdl/lpcd_dev.sv */
// Device end: decodes commands, tracks banks, stores masked write data.
// Assumes controller keeps its own timing obligations.
module lpcd_dev #(
  parameter int MEM_WORDS = 16
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  lpcd_if.dev                              link,
  output logic [lpcd_pkg::NBANK-1:0]       bank_open_o,
  output logic                             rd_busy_o,
  output logic                             refreshing_o,
  output logic                             self_refresh_o,
  output logic                             deep_power_down_o,
  output logic [lpcd_pkg::ROW_W-1:0]       refresh_row_o,
  output logic [lpcd_pkg::ADDR_W-1:0]      mode_std_o,
  output logic [lpcd_pkg::ADDR_W-1:0]      mode_ext_o,
  output logic [lpcd_pkg::ADDR_W-1:0]      mode_sts_o,
  output logic                             wr_strobe_o,
  output logic [$clog2(MEM_WORDS)-1:0]     wr_index_o,
  output logic [lpcd_pkg::DATA_W-1:0]      wr_word_o
);
  localparam int IW = $clog2(MEM_WORDS);
  localparam int CW = 8;
  localparam int FW = lpcd_pkg::DATA_W + lpcd_pkg::BYTES;
  // Refuse sizes the index and timer widths cannot serve
  if (MEM_WORDS < 2 || (1 << IW) != MEM_WORDS || lpcd_pkg::RFC_CYC > 255)
  begin : g_bad_param
    $error("lpcd_dev parameters out of range");
  end

  typedef struct packed {
    logic [lpcd_pkg::NBANK-1:0]                          open;
    logic [lpcd_pkg::NBANK-1:0][lpcd_pkg::ROW_W-1:0]     row;
    logic                                                rd_act;
    logic                                                rd_ap;
    logic [lpcd_pkg::BANK_W-1:0]                         rd_bank;
    logic [CW-1:0]                                       rd_cnt;
    logic                                                wr_act;
    logic                                                wr_ap;
    logic [lpcd_pkg::BANK_W-1:0]                         wr_bank;
    logic [CW-1:0]                                       wr_cnt;
    logic [IW-1:0]                                       wr_col;
    logic [CW-1:0]                                       ref_cnt;
    logic                                                refr;
    logic                                                sref;
    logic                                                deep_power_down;
    logic [lpcd_pkg::ROW_W-1:0]                          ref_row;
    logic [2:0][lpcd_pkg::ADDR_W-1:0]                    mode;
    logic [MEM_WORDS-1:0][lpcd_pkg::DATA_W-1:0]          mem;
    logic                                                wstb;
    logic [IW-1:0]                                       widx;
    logic [lpcd_pkg::DATA_W-1:0]                         wword;
  } lpcd_dev_s;

  lpcd_dev_s st_reg;
  lpcd_dev_s st_next;
  logic [3:0] cmd;
  logic       ap;
  logic       f_valid;
  logic       f_ready;
  logic [FW-1:0] f_data;
  logic [lpcd_pkg::DATA_W-1:0] merged;

  // Commands taken on the rising clock edge only
  assign cmd = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign ap  = link.addr[lpcd_pkg::AP_BIT];

  // Write data buffered ahead of the array
  lpcd_fifo #(
    .WIDTH (FW),
    .DEPTH (4)
  ) u_wfifo (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (link.wd_valid),
    .in_data_i   ({link.dm, link.wd}),
    .in_ready_o  (link.wd_ready),
    .out_valid_o (f_valid),
    .out_data_o  (f_data),
    .out_ready_i (f_ready)
  );

  // Drain only while a write burst needs beats
  assign f_ready = st_reg.wr_act && !st_reg.deep_power_down;

  // Byte merge: mask low writes, mask high keeps old byte
  always_comb
  begin
    merged = st_reg.mem[st_reg.wr_col];
    for (int b = 0; b < lpcd_pkg::BYTES; b++)
    begin
      if (!f_data[lpcd_pkg::DATA_W + b])
        merged[b*8 +: 8] = f_data[b*8 +: 8];
    end
  end

  // Command decode and bank bookkeeping
  always_comb
  begin
    st_next = st_reg;
    st_next.wstb = 1'b0;
    // Refresh timer runs regardless of new commands
    if (st_reg.ref_cnt != '0)
      st_next.ref_cnt = st_reg.ref_cnt - 1'b1;
    // Read burst countdown, auto precharge at end
    if (st_reg.rd_act)
    begin
      st_next.rd_cnt = st_reg.rd_cnt - 1'b1;
      if (st_reg.rd_cnt == CW'(1))
      begin
        st_next.rd_act = 1'b0;
        if (st_reg.rd_ap)
          st_next.open[st_reg.rd_bank] = 1'b0;
      end
    end
    // Write beats consume FIFO words
    if (f_ready && f_valid)
    begin
      st_next.mem[st_reg.wr_col] = merged;
      st_next.wstb  = 1'b1;
      st_next.widx  = st_reg.wr_col;
      st_next.wword = merged;
      st_next.wr_col = st_reg.wr_col + 1'b1;
      st_next.wr_cnt = st_reg.wr_cnt - 1'b1;
      if (st_reg.wr_cnt == CW'(1))
      begin
        st_next.wr_act = 1'b0;
        if (st_reg.wr_ap)
          st_next.open[st_reg.wr_bank] = 1'b0;
      end
    end
    if (st_reg.deep_power_down)
    begin
      // Array unpowered; leave only with reset
      st_next.mem = '0;
    end
    else if (st_reg.sref)
    begin
      if (link.cke)
        st_next.sref = 1'b0;
    end
    else if (cmd[3] || cmd == lpcd_pkg::LPCD_NOP)
    begin
      // Nothing new; bursts and refresh carry on
      st_next.sref = st_reg.sref;
    end
    else
    begin
      case (cmd)
        lpcd_pkg::LPCD_ACT:
        begin
          if (link.cke)
          begin
            st_next.open[link.ba] = 1'b1;
            st_next.row[link.ba]  = link.addr[lpcd_pkg::ROW_W-1:0];
          end
        end
        lpcd_pkg::LPCD_RD:
        begin
          st_next.rd_act  = 1'b1;
          st_next.rd_ap   = ap;
          st_next.rd_bank = link.ba;
          st_next.rd_cnt  = CW'(lpcd_pkg::BURST_LEN);
        end
        lpcd_pkg::LPCD_WR:
        begin
          st_next.wr_act  = 1'b1;
          st_next.wr_ap   = ap;
          st_next.wr_bank = link.ba;
          st_next.wr_cnt  = CW'(lpcd_pkg::BURST_LEN);
          st_next.wr_col  = link.addr[IW-1:0];
        end
        lpcd_pkg::LPCD_BST:
        begin
          if (link.cke)
            st_next.rd_act = 1'b0;
          else
            st_next.deep_power_down = 1'b1;
        end
        lpcd_pkg::LPCD_PRE:
        begin
          if (ap)
            st_next.open = '0;
          else
            st_next.open[link.ba] = 1'b0;
        end
        lpcd_pkg::LPCD_REF:
        begin
          st_next.ref_row = st_reg.ref_row + 1'b1;
          if (link.cke)
            st_next.ref_cnt = CW'(lpcd_pkg::RFC_CYC);
          else
            st_next.sref = 1'b1;
        end
        lpcd_pkg::LPCD_MRS:
        begin
          case (link.ba)
            lpcd_pkg::MR_STD: st_next.mode[0] = link.addr;
            lpcd_pkg::MR_EXT: st_next.mode[1] = link.addr;
            lpcd_pkg::MR_STS: st_next.mode[2] = link.addr;
            default:          st_next.mode[0] = st_reg.mode[0];
          endcase
        end
        default:
          st_next.sref = st_reg.sref;
      endcase
    end
    // Refresh flag registered so the output comes from a flop
    st_next.refr = (st_next.ref_cnt != '0);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign bank_open_o       = st_reg.open;
  assign rd_busy_o         = st_reg.rd_act;
  assign refreshing_o      = st_reg.refr;
  assign self_refresh_o    = st_reg.sref;
  assign deep_power_down_o = st_reg.deep_power_down;
  assign refresh_row_o     = st_reg.ref_row;
  assign mode_std_o        = st_reg.mode[0];
  assign mode_ext_o        = st_reg.mode[1];
  assign mode_sts_o        = st_reg.mode[2];
  assign wr_strobe_o       = st_reg.wstb;
  assign wr_index_o        = st_reg.widx;
  assign wr_word_o         = st_reg.wword;
endmodule : lpcd_dev

/* hdl/lpcd_ctrl.sv */
// Controller end: issues one user command, then holds off for its time.
// Assumes the user only asks for commands legal in the current state.
module lpcd_ctrl (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_n_i,
  lpcd_if.ctrl                             link,
  input  wire logic                        req_i,
  input  wire logic [3:0]                  req_cmd_i,
  input  wire logic                        req_cke_i,
  input  wire logic [lpcd_pkg::BANK_W-1:0] req_ba_i,
  input  wire logic [lpcd_pkg::ADDR_W-1:0] req_addr_i,
  input  wire logic                        wd_valid_i,
  input  wire logic [lpcd_pkg::DATA_W-1:0] wd_i,
  input  wire logic [lpcd_pkg::BYTES-1:0]  dm_i,
  output logic                             wd_ready_o,
  output logic                             busy_o
);
  localparam int CW = 8;

  typedef struct packed {
    logic                        cke;
    logic [3:0]                  cmd;
    logic [lpcd_pkg::BANK_W-1:0] ba;
    logic [lpcd_pkg::ADDR_W-1:0] addr;
    logic [CW-1:0]               wait_cnt;
    logic                        sref;
    logic                        busy;
  } lpcd_ctrl_s;

  lpcd_ctrl_s st_reg;
  lpcd_ctrl_s st_next;

  // One command per request, then blocked for its recovery time
  always_comb
  begin
    st_next = st_reg;
    st_next.cmd = lpcd_pkg::LPCD_NOP;
    if (st_reg.wait_cnt != '0)
      st_next.wait_cnt = st_reg.wait_cnt - 1'b1;
    if (st_reg.sref)
    begin
      st_next.cke = 1'b0;
      if (req_i && req_cke_i && st_reg.wait_cnt == '0)
      begin
        st_next.cke  = 1'b1;
        st_next.sref = 1'b0;
      end
    end
    else if (req_i && st_reg.wait_cnt == '0)
    begin
      st_next.cmd  = req_cmd_i;
      st_next.cke  = req_cke_i;
      st_next.ba   = req_ba_i;
      st_next.addr = req_addr_i;
      case (req_cmd_i)
        lpcd_pkg::LPCD_PRE:
          st_next.wait_cnt = CW'(lpcd_pkg::RP_CYC);
        lpcd_pkg::LPCD_REF:
        begin
          st_next.wait_cnt = CW'(lpcd_pkg::RFC_CYC);
          st_next.sref     = !req_cke_i;
        end
        lpcd_pkg::LPCD_MRS:
          st_next.wait_cnt = CW'(lpcd_pkg::MRD_CYC);
        lpcd_pkg::LPCD_RD,
        lpcd_pkg::LPCD_WR:
          st_next.wait_cnt = CW'(lpcd_pkg::BURST_LEN);
        default:
          st_next.wait_cnt = '0;
      endcase
    end
    else if (!st_reg.sref)
      st_next.cke = 1'b1;
    // Busy registered so the output comes from a flop
    st_next.busy = st_next.sref || (st_next.wait_cnt != '0);
  end

  // State register
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg     <= '0;
      st_reg.cke <= 1'b1;
      st_reg.cmd <= lpcd_pkg::LPCD_NOP;
    end
    else
      st_reg <= st_next;
  end

  assign link.cke      = st_reg.cke;
  assign link.cs_n     = st_reg.cmd[3];
  assign link.ras_n    = st_reg.cmd[2];
  assign link.cas_n    = st_reg.cmd[1];
  assign link.we_n     = st_reg.cmd[0];
  assign link.ba       = st_reg.ba;
  assign link.addr     = st_reg.addr;
  assign link.wd_valid = wd_valid_i;
  assign link.wd       = wd_i;
  assign link.dm       = dm_i;
  assign wd_ready_o    = link.wd_ready;
  assign busy_o        = st_reg.busy;
endmodule : lpcd_ctrl

/* dv/lpcd_chk.sv */
// Checker for the command link shared by controller and device ends.
// Assumes link signals, system clock and reset arrive as plain inputs.
module lpcd_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  // Command decode helpers
  logic [3:0] cmd;
  logic       nop;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign nop = cs_n || (cmd == 4'h7);
  // Link idle right after reset
  property p_rst_idle;
    $rose(rst_n_i) |-> nop && cke;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("link busy after reset");
  // Commands last one cycle
  property p_cmd_once;
    !nop |=> nop;
  endproperty
  a_cmd_once: assert property (p_cmd_once)
    else $error("command held past one cycle");
  // Precharge hold-off
  property p_pre_gap;
    cmd == 4'h2 |=> nop [*2];
  endproperty
  a_pre_gap: assert property (p_pre_gap)
    else $error("command inside precharge time");
  // Refresh hold-off
  property p_ref_gap;
    cmd == 4'h1 && cke |=> nop [*8];
  endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("command inside refresh time");
  // Mode load hold-off
  property p_mrs_gap;
    cmd == 4'h0 |=> nop [*2];
  endproperty
  a_mrs_gap: assert property (p_mrs_gap)
    else $error("command inside mode load time");
  // Burst hold-off
  property p_burst_gap;
    (cmd == 4'h5 || cmd == 4'h4) |=> nop [*4];
  endproperty
  a_burst_gap: assert property (p_burst_gap)
    else $error("command inside burst");
  // Self refresh entry keeps CKE low
  property p_sr_entry;
    cmd == 4'h1 && !cke |=> !cke;
  endproperty
  a_sr_entry: assert property (p_sr_entry)
    else $error("CKE rose right after self refresh entry");
  // No command while CKE stays low
  property p_sr_hold;
    !cke && $past(!cke) |-> nop;
  endproperty
  a_sr_hold: assert property (p_sr_hold)
    else $error("command sent with CKE low");
endmodule : lpcd_chk

/* dv/test_lpddr_command_decoder.sv */
// Testbench: both link ends joined, user and status sides checked.
// Assumes a 125 MHz clock and an async active-low reset.
module test_lpddr_command_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        req_i;
  logic [3:0]  req_cmd_i;
  logic        req_cke_i;
  logic [1:0]  req_ba_i;
  logic [13:0] req_addr_i;
  logic        wd_valid_i;
  logic [15:0] wd_i;
  logic [1:0]  dm_i;
  logic        wd_ready_o;
  logic        busy_o;
  logic [3:0]  bank_open_o;
  logic        rd_busy_o;
  logic        refreshing_o;
  logic        self_refresh_o;
  logic        deep_power_down_o;
  logic [13:0] refresh_row_o;
  logic [13:0] mode_std_o;
  logic [13:0] mode_ext_o;
  logic [13:0] mode_sts_o;
  logic        wr_strobe_o;
  logic [3:0]  wr_index_o;
  logic [15:0] wr_word_o;
  int          fail_count;
  int          check_count;
  ////////////////////////////////////////////////////////////
  // Both ends and the link watcher
  lpcd_if i_lpcd_if ();
  lpcd_ctrl i_lpcd_ctrl (.clk_sys_i, .rst_n_i, .link(i_lpcd_if), .req_i,
    .req_cmd_i, .req_cke_i, .req_ba_i, .req_addr_i, .wd_valid_i, .wd_i,
    .dm_i, .wd_ready_o, .busy_o);
  lpcd_dev i_lpcd_dev (.clk_sys_i, .rst_n_i, .link(i_lpcd_if),
    .bank_open_o, .rd_busy_o, .refreshing_o, .self_refresh_o,
    .deep_power_down_o, .refresh_row_o, .mode_std_o, .mode_ext_o,
    .mode_sts_o, .wr_strobe_o, .wr_index_o, .wr_word_o);
  lpcd_chk i_lpcd_chk (.clk_sys_i, .rst_n_i, .cke(i_lpcd_if.cke),
    .cs_n(i_lpcd_if.cs_n), .ras_n(i_lpcd_if.ras_n),
    .cas_n(i_lpcd_if.cas_n), .we_n(i_lpcd_if.we_n));
  // Clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  // Helpers
  task automatic complete_run();
    $display("checks %0d fails %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask : tick
  task automatic hang();
    fail_count++;
    complete_run();
  endtask : hang
  // One request, then two edges for the device to act
  task automatic issue(input logic [3:0] c, input logic k,
                       input logic [1:0] b, input logic [13:0] a);
    int i;
    for (i = 0; i < 40 && busy_o !== 1'b0; i++)
      tick(1);
    if (i == 40)
      hang();
    req_cmd_i = c;
    req_cke_i = k;
    req_ba_i = b;
    req_addr_i = a;
    req_i = 1'b1;
    tick(1);
    req_i = 1'b0;
    tick(2);
  endtask : issue
  // One write word into the device buffer; valid is left high
  task automatic push(input logic [15:0] d, input logic [1:0] m);
    int i;
    wd_i = d;
    dm_i = m;
    wd_valid_i = 1'b1;
    for (i = 0; i < 40 && wd_ready_o !== 1'b1; i++)
      tick(1);
    if (i == 40)
      hang();
    tick(1);
  endtask : push
  // Fill buffer till it refuses, write it, check each stored word
  // Masked bytes must keep the words of the first, unmasked burst
  task automatic t_write(input logic [13:0] a, input logic msk,
                         input logic [15:0] base);
    int n;
    logic [1:0] m;
    logic [15:0] d;
    logic [15:0] o;
    logic [15:0] keep;
    for (n = 0; n < 4; n++)
      push(base * 16'(n + 1), msk ? 2'(n) : 2'h0);
    wd_valid_i = 1'b0;
    chk(16'(wd_ready_o), 16'h0);
    issue(4'h4, 1'b1, 2'h1, a);
    n = 0;
    repeat (20)
    begin
      if (wr_strobe_o === 1'b1)
      begin
        d = base * 16'(n + 1);
        o = 16'h1111 * 16'(n + 1);
        m = msk ? 2'(n) : 2'h0;
        keep = {{8{!m[1]}}, {8{!m[0]}}};
        chk(16'(wr_index_o), 16'(a[3:0] + 4'(n)));
        chk(wr_word_o, (d & keep) | (o & ~keep));
        n++;
      end
      tick(1);
    end
    chk(16'(n), 16'h4);
  endtask : t_write
  // Plain read, terminate, then reads with and without auto precharge
  task automatic t_read();
    issue(4'h3, 1'b1, 2'h2, 14'h0033);
    issue(4'h5, 1'b1, 2'h2, 14'h0001);
    chk(16'(rd_busy_o), 16'h1);
    tick(8);
    chk(16'(rd_busy_o), 16'h0);
    chk(16'(bank_open_o), 16'h4);
    issue(4'h6, 1'b1, 2'h0, 14'h0000);
    chk(16'(bank_open_o), 16'h4);
    chk(16'(deep_power_down_o), 16'h0);
    issue(4'h5, 1'b1, 2'h2, 14'h0402);
    tick(8);
    chk(16'(bank_open_o), 16'h0);
    // Auto precharge must not carry over to the next read
    issue(4'h3, 1'b1, 2'h2, 14'h0033);
    issue(4'h5, 1'b1, 2'h2, 14'h0003);
    tick(8);
    chk(16'(bank_open_o), 16'h4);
    issue(4'h2, 1'b1, 2'h2, 14'h0000);
    chk(16'(bank_open_o), 16'h0);
  endtask : t_read
  // Idle commands, single and all-bank precharge
  // Chip select high with precharge-all lines must do nothing
  task automatic t_pre();
    issue(4'h3, 1'b1, 2'h0, 14'h0011);
    issue(4'h3, 1'b1, 2'h3, 14'h0022);
    issue(4'hA, 1'b1, 2'h0, 14'h0400);
    issue(4'h7, 1'b1, 2'h3, 14'h0400);
    chk(16'(bank_open_o), 16'h9);
    issue(4'h2, 1'b1, 2'h0, 14'h0000);
    chk(16'(bank_open_o), 16'h8);
    issue(4'h3, 1'b1, 2'h1, 14'h0044);
    issue(4'h2, 1'b1, 2'h1, 14'h0400);
    chk(16'(bank_open_o), 16'h0);
  endtask : t_pre
  // Each mode register, then a reserved bank code
  task automatic t_mrs();
    issue(4'h0, 1'b1, lpcd_pkg::MR_STD, 14'h0031);
    issue(4'h0, 1'b1, lpcd_pkg::MR_EXT, 14'h0042);
    issue(4'h0, 1'b1, lpcd_pkg::MR_STS, 14'h0053);
    issue(4'h0, 1'b1, 2'h3, 14'h3FFF);
    chk(16'(mode_std_o), 16'h0031);
    chk(16'(mode_ext_o), 16'h0042);
    chk(16'(mode_sts_o), 16'h0053);
  endtask : t_mrs
  // Auto refresh length, then self refresh entry and exit
  task automatic t_ref();
    int i;
    issue(4'h1, 1'b1, 2'h2, 14'h2AAA);
    chk(16'(refreshing_o), 16'h1);
    tick(lpcd_pkg::RFC_CYC - 2);
    chk(16'(refreshing_o), 16'h1);
    tick(1);
    chk(16'(refreshing_o), 16'h0);
    issue(4'h1, 1'b0, 2'h0, 14'h0000);
    chk(16'(self_refresh_o), 16'h1);
    tick(6);
    chk(16'(self_refresh_o), 16'h1);
    // Busy stands in self refresh: hold the exit request until taken
    req_cmd_i = 4'h7;
    req_cke_i = 1'b1;
    req_i = 1'b1;
    for (i = 0; i < 40 && busy_o !== 1'b0; i++)
      tick(1);
    if (i == 40)
      hang();
    req_i = 1'b0;
    tick(2);
    chk(16'(self_refresh_o), 16'h0);
    chk(16'(refresh_row_o), 16'h2);
  endtask : t_ref
  // Main sequence
  initial
  begin
    fail_count = 0;
    check_count = 0;
    rst_n_i = 1'b0;
    req_i = 1'b0;
    req_cmd_i = 4'h7;
    req_cke_i = 1'b1;
    req_ba_i = 2'h0;
    req_addr_i = 14'h0000;
    wd_valid_i = 1'b0;
    wd_i = 16'h0000;
    dm_i = 2'h0;
    tick(6);
    rst_n_i = 1'b1;
    chk(16'(bank_open_o), 16'h0);
    issue(4'h3, 1'b1, 2'h1, 14'h0005);
    chk(16'(bank_open_o), 16'h2);
    t_write(14'h0004, 1'b0, 16'h1111);
    chk(16'(bank_open_o), 16'h2);
    t_write(14'h0404, 1'b1, 16'h2222);
    chk(16'(bank_open_o), 16'h0);
    t_read();
    t_pre();
    t_mrs();
    t_ref();
    issue(4'h6, 1'b0, 2'h0, 14'h0000);
    chk(16'(deep_power_down_o), 16'h1);
    // Powered-down array refuses a later activate
    issue(4'h3, 1'b1, 2'h1, 14'h0005);
    chk(16'(bank_open_o), 16'h0);
    complete_run();
  end
endmodule : test_lpddr_command_decoder
